// ==== rtl/cspm_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module cspm_monitor #(
  parameter int unsigned SEG_CYCLES   = cspm_pkg::SEG_CYCLES,
  parameter int unsigned SEG_PER_CONV = cspm_pkg::SEG_PER_CONV
) (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     sys_rst_i,
  // Monitor enable register port
  input  wire logic                     mon_wr_i,
  input  wire logic [cspm_pkg::REG_W-1:0] mon_wdata_i,
  output logic [cspm_pkg::REG_W-1:0]    mon_rdata_o,
  // Control register event flag
  input  wire logic                     flag_clr_i,
  output logic                          pin_monitor_event_flag_o,
  // Output switching activity
  input  wire logic                     twowire_switch_i,
  input  wire logic                     serial_periph_switch_i,
  input  wire logic                     port_write_i,
  // Converter
  input  wire logic                     conv_start_i,
  output logic                          conv_busy_o,
  output logic                          conv_done_o,
  output logic                          seg_restart_o,
  output logic [2:0]                    retry_count_o
);
  localparam int unsigned SW = $clog2(SEG_PER_CONV + 1);

  logic [cspm_pkg::REG_W-1:0] mon_q;
  logic                       flag_q;
  logic [2:0]                 retry_q;
  logic [SW-1:0]              seg_q;
  logic                       hit_q;
  cspm_pkg::cspm_state_e      state_q;
  logic                       disturb;
  logic                       at_limit;
  logic                       retry;
  logic                       seg_end;
  logic                       timer_restart;
  logic                       timer_expired;

  function automatic logic limit_hit(input logic [1:0] sel, input logic [2:0] cnt);
    case (sel)
      cspm_pkg::LIMIT_TWO:  limit_hit = (cnt >= cspm_pkg::LIMIT_TWO_COUNT);
      cspm_pkg::LIMIT_FOUR: limit_hit = (cnt >= cspm_pkg::LIMIT_FOUR_COUNT);
      default:              limit_hit = 1'b0;
    endcase
  endfunction

  // Enables register
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      mon_q <= cspm_pkg::MON_EN_RESET;
    else if (mon_wr_i)
      mon_q <= mon_wdata_i;
  end
  assign mon_rdata_o = mon_q;

  // Switching on any enabled source
  assign disturb = (mon_q[cspm_pkg::BIT_TWOWIRE] && twowire_switch_i)
                || (mon_q[cspm_pkg::BIT_SERIAL] && serial_periph_switch_i)
                || (mon_q[cspm_pkg::BIT_PORTWR] && port_write_i);

  assign at_limit = limit_hit(mon_q[cspm_pkg::LIMIT_LSB +: 2], retry_q);
  assign seg_end  = (state_q == cspm_pkg::CSPM_SEG) && timer_expired;
  assign retry    = seg_end && (hit_q || disturb) && !at_limit;

  assign timer_restart = (conv_start_i && (state_q == cspm_pkg::CSPM_IDLE)) || seg_end;

  cspm_seg_timer #(
    .CYCLES    (SEG_CYCLES)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (timer_restart),
    .run_i     (state_q == cspm_pkg::CSPM_SEG),
    .expired_o (timer_expired)
  );

  // Disturbance seen during the current segment
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || timer_restart)
      hit_q <= 1'b0;
    else if (state_q == cspm_pkg::CSPM_SEG && disturb)
      hit_q <= 1'b1;
  end

  // Sequencer
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      state_q <= cspm_pkg::CSPM_IDLE;
    else
      case (state_q)
        cspm_pkg::CSPM_IDLE:
          if (conv_start_i)
            state_q <= cspm_pkg::CSPM_SEG;
        cspm_pkg::CSPM_SEG:
          if (seg_end && !retry && seg_q == SW'(SEG_PER_CONV - 1))
            state_q <= cspm_pkg::CSPM_SETTLE;
        cspm_pkg::CSPM_SETTLE:
          state_q <= cspm_pkg::CSPM_DONE;
        cspm_pkg::CSPM_DONE:
          state_q <= cspm_pkg::CSPM_IDLE;
        default:
          state_q <= cspm_pkg::CSPM_IDLE;
      endcase
  end

  // Segment index; a retry repeats the same segment
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || state_q == cspm_pkg::CSPM_IDLE)
      seg_q <= '0;
    else if (seg_end && !retry)
      seg_q <= seg_q + SW'(1);
  end

  // Retries per conversion
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || (state_q == cspm_pkg::CSPM_IDLE && conv_start_i))
      retry_q <= '0;
    else if (retry && retry_q != 3'h7)
      retry_q <= retry_q + 3'h1;
  end

  // Sticky event flag; set wins over clear
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      flag_q <= 1'b0;
    else if (retry)
      flag_q <= 1'b1;
    else if (flag_clr_i)
      flag_q <= 1'b0;
  end

  assign pin_monitor_event_flag_o = flag_q;
  assign conv_busy_o              = state_q != cspm_pkg::CSPM_IDLE;
  assign conv_done_o              = state_q == cspm_pkg::CSPM_DONE;
  assign seg_restart_o            = retry;
  assign retry_count_o            = retry_q;
endmodule // cspm_monitor
`default_nettype wire

// ==== rtl/cspm_pkg.sv ====
package cspm_pkg;
  localparam int unsigned        REG_W            = 8;
  localparam int unsigned        BIT_TWOWIRE      = 7;
  localparam int unsigned        BIT_SERIAL       = 6;
  localparam int unsigned        BIT_PORTWR       = 5;
  localparam int unsigned        LIMIT_LSB        = 2;
  localparam logic [REG_W-1:0]   MON_EN_RESET     = 8'h00;
  localparam logic [1:0]         LIMIT_NONE       = 2'h0;
  localparam logic [1:0]         LIMIT_TWO        = 2'h1;
  localparam logic [1:0]         LIMIT_FOUR       = 2'h2;
  localparam logic [2:0]         LIMIT_TWO_COUNT  = 3'h2;
  localparam logic [2:0]         LIMIT_FOUR_COUNT = 3'h4;
  localparam int unsigned        SEG_CYCLES       = 16;
  localparam int unsigned        SEG_PER_CONV     = 4;

  typedef enum logic [1:0] {
    CSPM_IDLE   = 2'b00,
    CSPM_SEG    = 2'b01,
    CSPM_SETTLE = 2'b11,
    CSPM_DONE   = 2'b10
  } cspm_state_e;
endpackage : cspm_pkg

// ==== rtl/cspm_seg_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Counts cycles of one conversion segment; restart reloads it
module cspm_seg_timer #(
  parameter int unsigned CYCLES = 16
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  // Control
  input  wire logic restart_i,
  input  wire logic run_i,
  output logic      expired_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || restart_i)
      cnt_q <= '0;
    else if (run_i && cnt_q != LAST)
      cnt_q <= cnt_q + CW'(1);
  end

  assign expired_o = run_i && (cnt_q == LAST);
endmodule // cspm_seg_timer
`default_nettype wire

// ==== dv/cspm_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module cspm_asserts (
  // Clock and reset
  input wire logic                       clk_sys_i,
  input wire logic                       sys_rst_i,
  // Watched ports
  input wire logic [cspm_pkg::REG_W-1:0] mon_rdata_o,
  input wire logic                       flag_clr_i,
  input wire logic                       pin_monitor_event_flag_o,
  input wire logic                       conv_start_i,
  input wire logic                       conv_busy_o,
  input wire logic                       conv_done_o,
  input wire logic                       seg_restart_o,
  input wire logic [2:0]                 retry_count_o
);
  logic [1:0] lim;
  assign lim = mon_rdata_o[3:2];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  flag_set_a:
    assert property (seg_restart_o |=> pin_monitor_event_flag_o) else $error("flag not set");
  flag_hold_a:
    assert property (pin_monitor_event_flag_o && !flag_clr_i |=> pin_monitor_event_flag_o)
    else $error("flag dropped");
  cap_two_a:
    assert property (lim == cspm_pkg::LIMIT_TWO && retry_count_o >= 3'h2 |-> !seg_restart_o)
    else $error("retry past two");
  cap_four_a:
    assert property (lim == cspm_pkg::LIMIT_FOUR && retry_count_o >= 3'h4 |-> !seg_restart_o)
    else $error("retry past four");
  count_step_a:
    assert property (seg_restart_o && retry_count_o != 3'h7 |=>
      retry_count_o == $past(retry_count_o) + 3'h1) else $error("count not stepped");
  start_clear_a:
    assert property (conv_start_i && !conv_busy_o && !conv_done_o |=>
      conv_busy_o && retry_count_o == 3'h0) else $error("bad start");
  src_gate_a:
    assert property (seg_restart_o |-> conv_busy_o && mon_rdata_o[7:5] != 3'h0)
    else $error("retry without enable");
  rst_val_a:
    assert property ($fell(sys_rst_i) |-> mon_rdata_o == cspm_pkg::MON_EN_RESET)
    else $error("bad reset value");
endmodule // cspm_asserts
bind cspm_monitor cspm_asserts u_asserts (.clk_sys_i, .sys_rst_i, .mon_rdata_o, .flag_clr_i,
  .pin_monitor_event_flag_o, .conv_start_i, .conv_busy_o, .conv_done_o, .seg_restart_o,
  .retry_count_o);
`default_nettype wire

// ==== dv/tb_cap_sense_pin_monitor_retry.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_cap_sense_pin_monitor_retry;
  logic       clk_sys_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       mon_wr    = 1'b0;
  logic       flag_clr  = 1'b0;
  logic       start     = 1'b0;
  logic [7:0] wdata     = 8'h00;
  logic [2:0] sw        = 3'h0;
  logic [7:0] rdata;
  logic [2:0] cnt;
  logic       flag;
  logic       done;
  logic       busy;
  int         failures  = 0;
  int         n_checks  = 0;
  int         cyc       = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  cspm_monitor DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .mon_wr_i(mon_wr),
    .mon_wdata_i(wdata), .mon_rdata_o(rdata), .flag_clr_i(flag_clr),
    .pin_monitor_event_flag_o(flag), .twowire_switch_i(sw[2]), .serial_periph_switch_i(sw[1]),
    .port_write_i(sw[0]), .conv_start_i(start), .conv_busy_o(busy), .conv_done_o(done),
    .seg_restart_o(), .retry_count_o(cnt));
  // Switching over three segments: expected retries after the cap
  function automatic logic [7:0] exp_cnt(input logic [7:0] w, input int s);
    if (!w[5+s])
      return 8'h00;
    return (w[3:2] == cspm_pkg::LIMIT_TWO) ? 8'h02 : 8'h03;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic conv(input logic [7:0] w, input int s);
    int k;
    @(posedge clk_sys_i);
    mon_wr <= 1'b1;
    wdata <= w;
    flag_clr <= 1'b1;
    @(posedge clk_sys_i);
    mon_wr <= 1'b0;
    flag_clr <= 1'b0;
    @(posedge clk_sys_i);
    chk(rdata & 8'hec, w & 8'hec);
    chk({7'h00, flag}, 8'h00);
    start <= 1'b1;
    sw[s] <= 1'b1;
    @(posedge clk_sys_i);
    start <= 1'b0;
    repeat (39) @(posedge clk_sys_i);
    sw <= 3'h0;
    k = 0;
    while (done !== 1'b1 && k < 400)
    begin
      @(posedge clk_sys_i);
      k++;
    end
    if (k == 400)
      failures++;
    repeat (3) @(posedge clk_sys_i);
    chk({7'h00, busy}, 8'h00);
    chk({5'h00, cnt}, exp_cnt(w, s));
    chk({7'h00, flag}, {7'h00, exp_cnt(w, s) != 8'h00});
  endtask
  initial
  begin
    void'($urandom(24947));
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk(rdata, cspm_pkg::MON_EN_RESET);
    for (int i = 0; i < 12; i++)
    begin
      conv({(i % 2 == 0) ? 3'h7 : 3'($urandom), 1'b0, 2'((i / 3) % 3), 2'h0}, i % 3);
      $display("test %0d done", i);
    end
    complete_run();
  end
endmodule // tb_cap_sense_pin_monitor_retry
`default_nettype wire
